// >>> hw/mcs_pkg.sv
// package: constants, field layout and types of the main clock switchover block
package mcs_pkg;

   // apb register map
   localparam int         ADDR_W       = 8;
   localparam logic [7:0] CKC_OFS      = 8'h00;
   localparam logic [7:0] OSC_OFS      = 8'h04;

   // clock_control_reg fields
   localparam int         DIV_LSB      = 0;
   localparam int         DIV_W        = 3;
   localparam int         SRC_SEL_BIT  = 4;
   localparam int         SRC_STAT_BIT = 5;
   localparam int         BUSY_BIT     = 6;

   // oscillator control register fields
   localparam int         INT_STOP_BIT = 0;
   localparam int         SYS_STOP_BIT = 1;
   localparam int         FAST_EN_BIT  = 2;
   localparam int         FAST_SEL_BIT = 3;

   // values after reset
   localparam logic [2:0] DIV_RST      = 3'h0;
   localparam logic       SRC_SEL_RST  = 1'b0;
   localparam logic       INT_STOP_RST = 1'b0;
   localparam logic       SYS_STOP_RST = 1'b0;
   localparam logic       FAST_EN_RST  = 1'b0;
   localparam logic       FAST_SEL_RST = 1'b0;

   // divider counter width, covers division by up to 128
   localparam int         DIV_CNT_W    = 7;
   localparam logic [6:0] DIV_CNT_RST  = 7'h00;

   // clock sources and their position in the tick vector
   localparam int         NUM_SRC      = 3;
   localparam int         IDX_INT      = 0;
   localparam int         IDX_FAST     = 1;
   localparam int         IDX_SYS      = 2;

   typedef enum logic [1:0] {
      SRC_INT  = 2'b00,
      SRC_FAST = 2'b01,
      SRC_SYS  = 2'b10
   } mcs_src_e;

   typedef struct packed {
      mcs_src_e   src;
      logic [2:0] div;
   } mcs_cfg_s;

   localparam mcs_cfg_s CFG_RST = '{src: SRC_INT, div: DIV_RST};

   typedef enum logic [1:0] {
      ST_RUN     = 2'b00,
      ST_RELEASE = 2'b01,
      ST_ACQUIRE = 2'b10
   } mcs_state_e;

endpackage

// >>> hw/mcs_tick_sync.sv
// module: synchronises asynchronous source clocks and marks their rising edges
`timescale 1ns/1ps
module mcs_tick_sync #(
   parameter int WIDTH = 3
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // asynchronous source clocks
   input  wire logic [WIDTH-1:0] src_async,
   // one-cycle pulse per rising edge
   output logic      [WIDTH-1:0] src_tick
);

   logic [WIDTH-1:0] meta_reg;
   logic [WIDTH-1:0] sync_reg;
   logic [WIDTH-1:0] last_reg;

   // first stage feeds only the second stage
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= '0;
         sync_reg <= '0;
         last_reg <= '0;
      end else begin
         meta_reg <= src_async;
         sync_reg <= meta_reg;
         last_reg <= sync_reg;
      end
   end

   assign src_tick = sync_reg & ~last_reg;

endmodule

// >>> hw/mcs_main_clock.sv
// module: main clock source and divider selection with glitch-free switchover
//
// The address map and the APB slave port were left to the implementer.
`timescale 1ns/1ps
module mcs_main_clock
   import mcs_pkg::*;
(
   // clock and reset
   input  wire logic              CORE_CLK,
   input  wire logic              RESETN,
   // apb slave
   input  wire logic              PSEL,
   input  wire logic              PENABLE,
   input  wire logic              PWRITE,
   input  wire logic [ADDR_W-1:0] PADDR,
   input  wire logic [31:0]       PWDATA,
   output logic      [31:0]       PRDATA,
   output logic                   PREADY,
   output logic                   PSLVERR,
   // asynchronous oscillator clocks
   input  wire logic              INT_OSC_CLK,
   input  wire logic              FAST_OSC_CLK,
   input  wire logic              SYS_CLK,
   // clock enables towards cpu and peripherals
   output logic                   CPU_CLK_EN,
   output logic                   PER_CLK_EN,
   // oscillator run controls
   output logic                   INT_OSC_RUN,
   output logic                   FAST_OSC_RUN,
   output logic                   SYS_CLK_RUN,
   // source status
   output logic                   MAIN_SRC_STATUS
);

   // ratio 2**div minus one, as the wrap value of the divider
   function automatic logic [DIV_CNT_W-1:0] ratio_m1(input logic [2:0] div);
      logic [DIV_CNT_W:0] one_hot;
      one_hot  = '0;
      one_hot[div] = 1'b1;
      ratio_m1 = one_hot[DIV_CNT_W-1:0] - 7'h01;
   endfunction

   // edge pulse of the selected source
   function automatic logic src_tick_of(input mcs_src_e       src,
                                        input logic [NUM_SRC-1:0] ticks);
      logic t;
      t = 1'b0;
      unique case (src)
         SRC_INT:  t = ticks[IDX_INT];
         SRC_FAST: t = ticks[IDX_FAST];
         SRC_SYS:  t = ticks[IDX_SYS];
         default:  t = 1'b0;
      endcase
      src_tick_of = t;
   endfunction

   // source is driving, or about to drive, the main clock
   function automatic logic src_used(input mcs_src_e s,
                                     input mcs_cfg_s cur,
                                     input mcs_cfg_s pend);
      src_used = (cur.src == s) || (pend.src == s);
   endfunction

   // software controlled state
   logic [2:0]           div_reg;
   logic                 src_sel_reg;
   logic                 int_stop_reg;
   logic                 sys_stop_reg;
   logic                 fast_en_reg;
   logic                 fast_sel_reg;

   // switchover state
   mcs_cfg_s             cur_reg;
   mcs_cfg_s             cur_next;
   mcs_state_e           state_reg;
   mcs_state_e           state_next;
   logic [DIV_CNT_W-1:0] cnt_reg;
   logic [DIV_CNT_W-1:0] cnt_next;

   // output flops
   logic                 clk_en_reg;
   logic                 clk_en_next;
   logic [31:0]          rdata_reg;
   logic                 int_run_reg;
   logic                 fast_run_reg;
   logic                 sys_run_reg;

   // decode wires
   logic [NUM_SRC-1:0]   src_ticks;
   logic                 setup_cyc;
   logic                 access_cyc;
   logic                 hit_ckc;
   logic                 hit_osc;
   logic                 addr_hit;
   logic                 wr_ckc;
   logic                 wr_osc;
   logic [31:0]          rd_mux;
   mcs_cfg_s             pend_cfg;
   mcs_src_e             pend_src;
   logic                 old_tick;
   logic                 new_tick;
   logic                 div_wrap;
   logic                 cfg_change;

   // oscillators come from other domains: two flops before any use
   mcs_tick_sync #(
      .WIDTH     (NUM_SRC)
   ) u_tick_sync (
      .clk       (CORE_CLK),
      .rst_n     (RESETN),
      .src_async ({SYS_CLK, FAST_OSC_CLK, INT_OSC_CLK}),
      .src_tick  (src_ticks)
   );

   // ------------------------------------------------------------ apb decode
   assign setup_cyc  = PSEL & ~PENABLE;
   assign access_cyc = PSEL & PENABLE;
   assign hit_ckc    = (PADDR == CKC_OFS);
   assign hit_osc    = (PADDR == OSC_OFS);
   assign addr_hit   = hit_ckc | hit_osc;
   assign wr_ckc     = access_cyc & PWRITE & hit_ckc;
   assign wr_osc     = access_cyc & PWRITE & hit_osc;

   // zero wait states; unmapped addresses answer with an error
   assign PREADY     = access_cyc;
   assign PSLVERR    = access_cyc & ~addr_hit;
   assign PRDATA     = rdata_reg;

   always_comb begin
      rd_mux = 32'h0000_0000;
      if (hit_ckc) begin
         rd_mux[DIV_LSB +: DIV_W] = div_reg;
         rd_mux[SRC_SEL_BIT]      = src_sel_reg;
         rd_mux[SRC_STAT_BIT]     = (cur_reg.src == SRC_SYS);
         rd_mux[BUSY_BIT]         = (state_reg != ST_RUN);
      end else if (hit_osc) begin
         rd_mux[INT_STOP_BIT]     = int_stop_reg;
         rd_mux[SYS_STOP_BIT]     = sys_stop_reg;
         rd_mux[FAST_EN_BIT]      = fast_en_reg;
         rd_mux[FAST_SEL_BIT]     = fast_sel_reg;
      end
   end

   // read data is captured in the setup cycle, held through the access
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         rdata_reg <= 32'h0000_0000;
      end else if (setup_cyc) begin
         rdata_reg <= rd_mux;
      end
   end

   // ------------------------------------------------------------ registers
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         div_reg     <= DIV_RST;
         src_sel_reg <= SRC_SEL_RST;
      end else if (wr_ckc) begin
         div_reg     <= PWDATA[DIV_LSB +: DIV_W];
         src_sel_reg <= PWDATA[SRC_SEL_BIT];
      end
   end

   // stop requests are stored as written; the run outputs gate them
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         int_stop_reg <= INT_STOP_RST;
         sys_stop_reg <= SYS_STOP_RST;
         fast_en_reg  <= FAST_EN_RST;
         fast_sel_reg <= FAST_SEL_RST;
      end else if (wr_osc) begin
         int_stop_reg <= PWDATA[INT_STOP_BIT];
         sys_stop_reg <= PWDATA[SYS_STOP_BIT];
         fast_en_reg  <= PWDATA[FAST_EN_BIT];
         fast_sel_reg <= PWDATA[FAST_SEL_BIT];
      end
   end

   // ------------------------------------------------------------ switchover
   // system clock wins over the internal pair; fast select picks within it
   assign pend_src = src_sel_reg  ? SRC_SYS  :
                     fast_sel_reg ? SRC_FAST : SRC_INT;
   assign pend_cfg = '{src: pend_src, div: div_reg};

   assign old_tick   = src_tick_of(cur_reg.src, src_ticks);
   assign new_tick   = src_tick_of(pend_cfg.src, src_ticks);
   assign div_wrap   = (cnt_reg == ratio_m1(cur_reg.div));
   assign cfg_change = (pend_cfg != cur_reg);

   // release waits one old cpu clock, acquire at most one new source edge,
   // so the wait stays within the old-clock bounds, fraction dropped
   always_comb begin
      state_next  = state_reg;
      cur_next    = cur_reg;
      cnt_next    = cnt_reg;
      clk_en_next = 1'b0;
      unique case (state_reg)
         ST_RUN: begin
            if (old_tick) begin
               cnt_next    = div_wrap ? DIV_CNT_RST : cnt_reg + 7'h01;
               clk_en_next = div_wrap;
            end
            if (cfg_change) begin
               state_next = ST_RELEASE;
            end
         end
         ST_RELEASE: begin
            // old clock still drives the cpu until its next full period
            if (old_tick) begin
               cnt_next    = div_wrap ? DIV_CNT_RST : cnt_reg + 7'h01;
               clk_en_next = div_wrap;
               if (div_wrap) begin
                  state_next = ST_ACQUIRE;
               end
            end
         end
         ST_ACQUIRE: begin
            // no pulses here: hold until the new source shows an edge
            if (new_tick) begin
               cur_next   = pend_cfg;
               cnt_next   = DIV_CNT_RST;
               state_next = ST_RUN;
            end
         end
         default: begin
            state_next = ST_RUN;
         end
      endcase
   end

   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         state_reg <= ST_RUN;
         cur_reg   <= CFG_RST;
         cnt_reg   <= DIV_CNT_RST;
      end else begin
         state_reg <= state_next;
         cur_reg   <= cur_next;
         cnt_reg   <= cnt_next;
      end
   end

   // one enable feeds both consumers so they can never drift apart
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         clk_en_reg <= 1'b0;
      end else begin
         clk_en_reg <= clk_en_next;
      end
   end

   assign CPU_CLK_EN      = clk_en_reg;
   assign PER_CLK_EN      = clk_en_reg;
   assign MAIN_SRC_STATUS = (cur_reg.src == SRC_SYS);

   // ------------------------------------------------------------ oscillators
   // a source in use, or pending, keeps running whatever software asked;
   // stopping it would freeze the switchover with no clock to leave on
   always_ff @(posedge CORE_CLK or negedge RESETN) begin
      if (!RESETN) begin
         int_run_reg  <= 1'b1;
         fast_run_reg <= 1'b0;
         sys_run_reg  <= 1'b1;
      end else begin
         int_run_reg  <= ~int_stop_reg
                         | src_used(SRC_INT, cur_reg, pend_cfg);
         sys_run_reg  <= ~sys_stop_reg
                         | src_used(SRC_SYS, cur_reg, pend_cfg);
         fast_run_reg <= fast_en_reg
                         | src_used(SRC_FAST, cur_reg, pend_cfg);
      end
   end

   assign INT_OSC_RUN  = int_run_reg;
   assign FAST_OSC_RUN = fast_run_reg;
   assign SYS_CLK_RUN  = sys_run_reg;

endmodule

// >>> verification/mcs_main_clock_chk.sv
// checker: port-level properties of the main clock switchover block
`timescale 1ns/1ps
module mcs_main_clock_chk
   import mcs_pkg::*;
(
   // clock and reset
   input wire logic              CORE_CLK,
   input wire logic              RESETN,
   // apb
   input wire logic              PSEL,
   input wire logic              PENABLE,
   input wire logic              PWRITE,
   input wire logic [ADDR_W-1:0] PADDR,
   input wire logic [31:0]       PRDATA,
   input wire logic              PREADY,
   input wire logic              PSLVERR,
   // clock side
   input wire logic              CPU_CLK_EN,
   input wire logic              PER_CLK_EN,
   input wire logic              INT_OSC_RUN,
   input wire logic              FAST_OSC_RUN,
   input wire logic              SYS_CLK_RUN,
   input wire logic              MAIN_SRC_STATUS
);
   default clocking @(posedge CORE_CLK); endclocking
   default disable iff (!RESETN);
   wire acc    = PSEL && PENABLE;
   wire mapped = (PADDR == CKC_OFS) || (PADDR == OSC_OFS);

   per_same_a: assert property (PER_CLK_EN == CPU_CLK_EN)
      else $error("peripheral enable differs from cpu enable");
   zero_wait_a: assert property (PREADY == acc)
      else $error("ready not tied to access phase");
   map_err_a: assert property (acc |-> PSLVERR == !mapped)
      else $error("error response does not match address map");
   unmapped_zero_a: assert property (acc && !PWRITE && !mapped |-> PRDATA == 32'h0)
      else $error("unmapped read returned nonzero data");
   pulse_gap_a: assert property (CPU_CLK_EN |=> !CPU_CLK_EN [*3])
      else $error("cpu enable pulses too close together");
   int_stop_a: assert property (!INT_OSC_RUN |-> MAIN_SRC_STATUS)
      else $error("internal oscillator stopped while in use");
   sys_stop_a: assert property (!SYS_CLK_RUN |-> !MAIN_SRC_STATUS)
      else $error("system clock stopped while in use");
   rst_vals_a: assert property ($rose(RESETN) |-> INT_OSC_RUN && SYS_CLK_RUN
      && !FAST_OSC_RUN && !MAIN_SRC_STATUS && !CPU_CLK_EN)
      else $error("outputs not at reset values");
   switch_quiet_a: assert property ($changed(MAIN_SRC_STATUS) |-> !CPU_CLK_EN)
      else $error("pulse at the source change edge");

   cover property (CPU_CLK_EN);
   cover property ($rose(MAIN_SRC_STATUS));
   cover property ($fell(FAST_OSC_RUN));
endmodule

bind mcs_main_clock mcs_main_clock_chk chk_u (
   .CORE_CLK(CORE_CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE),
   .PWRITE(PWRITE), .PADDR(PADDR), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR),
   .CPU_CLK_EN(CPU_CLK_EN), .PER_CLK_EN(PER_CLK_EN), .INT_OSC_RUN(INT_OSC_RUN),
   .FAST_OSC_RUN(FAST_OSC_RUN), .SYS_CLK_RUN(SYS_CLK_RUN),
   .MAIN_SRC_STATUS(MAIN_SRC_STATUS));

// >>> verification/tb.sv
// testbench: register access, source and ratio switches, oscillator controls
`timescale 1ns/1ps
module tb
   import mcs_pkg::*;
;
   localparam int     TI = 402;
   localparam int     TM = 598;
   logic              CORE_CLK = 1'b0;
   logic              RESETN = 1'b0;
   logic              PSEL = 1'b0;
   logic              PENABLE = 1'b0;
   logic              PWRITE = 1'b0;
   logic [ADDR_W-1:0] PADDR = '0;
   logic [31:0]       PWDATA = '0;
   logic [31:0]       PRDATA;
   logic              PREADY, PSLVERR, CPU_CLK_EN, PER_CLK_EN, MAIN_SRC_STATUS;
   logic              INT_OSC_RUN, FAST_OSC_RUN, SYS_CLK_RUN;
   logic              int_raw = 1'b0;
   logic              sys_raw = 1'b0;
   logic              fast_raw = 1'b0;
   logic [64:0]       exp_q[$];
   int                bad_count = 0;
   int                n_checks = 0;
   int                pulses = 0;
   int                p0 = 0;
   integer            seed = 32'hd7c383a8;

   always #25 CORE_CLK = ~CORE_CLK;
   // odd half periods keep the sources drifting against the core clock
   always #(TI / 2) int_raw = ~int_raw;
   always #(TM / 2) sys_raw = ~sys_raw;
   always #151 fast_raw = ~fast_raw;

   mcs_main_clock dut_u (
      .CORE_CLK(CORE_CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE),
      .PWRITE(PWRITE), .PADDR(PADDR), .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY),
      .PSLVERR(PSLVERR), .INT_OSC_CLK(int_raw & INT_OSC_RUN),
      .FAST_OSC_CLK(fast_raw & FAST_OSC_RUN), .SYS_CLK(sys_raw & SYS_CLK_RUN),
      .CPU_CLK_EN(CPU_CLK_EN), .PER_CLK_EN(PER_CLK_EN), .INT_OSC_RUN(INT_OSC_RUN),
      .FAST_OSC_RUN(FAST_OSC_RUN), .SYS_CLK_RUN(SYS_CLK_RUN),
      .MAIN_SRC_STATUS(MAIN_SRC_STATUS));

   always @(posedge CORE_CLK)
      if (CPU_CLK_EN === 1'b1)
         pulses <= pulses + 1;

   task automatic chk(input string nm, input logic [32:0] s, input logic [32:0] e);
      n_checks++;
      if (s !== e) begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, e, s);
      end
   endtask

   task automatic finish_test;
      if (bad_count == 0 && n_checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   always @(posedge CORE_CLK) begin
      logic [64:0] e;
      if (PSEL && PENABLE && PREADY === 1'b1 && !PWRITE && exp_q.size() > 0) begin
         e = exp_q.pop_front();
         chk("read", {PSLVERR, PRDATA & e[63:32]}, {e[64], e[31:0]});
      end
   end

   // keep holds psel high for a back-to-back setup
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                      input logic [31:0] m, input logic keep, output logic [31:0] r);
      if (!w)
         exp_q.push_back({(a != CKC_OFS && a != OSC_OFS), m, d});
      PSEL <= 1'b1;
      PWRITE <= w;
      PADDR <= a;
      PWDATA <= d;
      @(posedge CORE_CLK);
      PENABLE <= 1'b1;
      do @(posedge CORE_CLK); while (PREADY !== 1'b1);
      r = PRDATA;
      PENABLE <= 1'b0;
      // an idle edge after a release, so the next setup never re-drives psel in this step
      if (!keep) begin
         PSEL <= 1'b0;
         @(posedge CORE_CLK);
      end
   endtask

   // busy may not show yet in the first edges after a write
   task automatic settle;
      logic [31:0] r;
      int          n;
      n = 0;
      repeat (3) @(posedge CORE_CLK);
      p0 = pulses;
      do begin
         apb(1'b0, CKC_OFS, 32'h0, 32'h0, 1'b1, r);
         n++;
      end while (r[BUSY_BIT] !== 1'b0 && n < 400);
      chk("busy", {32'h0, r[BUSY_BIT]}, 33'h0);
      PSEL <= 1'b0;
      @(posedge CORE_CLK);
   endtask

   task automatic runs(input logic [2:0] e);
      chk("osc run", {30'h0, INT_OSC_RUN, FAST_OSC_RUN, SYS_CLK_RUN}, {30'h0, e});
   endtask

   task automatic switch_to(input logic s, input logic [2:0] dv, input int bound);
      logic [31:0] r;
      logic [31:0] v;
      v = 32'(dv) | (32'(s) << SRC_SEL_BIT);
      apb(1'b1, CKC_OFS, v, 32'h0, 1'b0, r);
      settle();
      chk("old pulses", 33'(pulses - p0 <= bound), 33'h1);
      apb(1'b0, CKC_OFS, v | (32'(s) << SRC_STAT_BIT), 32'h7f, 1'b0, r);
      chk("status pin", {32'h0, MAIN_SRC_STATUS}, {32'h0, s});
   endtask

   initial begin
      logic [31:0] r;
      logic [2:0]  nd;
      repeat (16) @(posedge CORE_CLK);
      RESETN <= 1'b1;
      @(posedge CORE_CLK);
      runs(3'b101);
      apb(1'b0, CKC_OFS, 32'h0, 32'hffffffff, 1'b0, r);
      apb(1'b0, OSC_OFS, 32'h0, 32'hffffffff, 1'b1, r);
      apb(1'b1, 8'h08, $random(seed), 32'h0, 1'b1, r);
      apb(1'b0, 8'h08, 32'h0, 32'hffffffff, 1'b1, r);
      apb(1'b1, CKC_OFS, 32'h60, 32'h0, 1'b0, r);
      apb(1'b0, CKC_OFS, 32'h0, 32'h7f, 1'b0, r);
      switch_to(1'b0, 3'h1, 1 + 2 / 1);
      switch_to(1'b0, 3'h0, 1 + 1 / 2);
      nd = 3'($unsigned($random(seed)) % 3);
      switch_to(1'b0, nd, 1 + (1 << nd));
      switch_to(1'b0, 3'h0, 1 + 1 / (1 << nd));
      switch_to(1'b1, 3'h0, (TM <= TI) ? 1 + TM / TI : 2 * TM / TI);
      apb(1'b1, OSC_OFS, 32'h3, 32'h0, 1'b0, r);
      repeat (4) @(posedge CORE_CLK);
      runs(3'b001);
      apb(1'b0, OSC_OFS, 32'h3, 32'hf, 1'b0, r);
      apb(1'b1, OSC_OFS, 32'h2, 32'h0, 1'b0, r);
      repeat (4) @(posedge CORE_CLK);
      switch_to(1'b0, 3'h0, (TM <= TI) ? 2 * TI / TM : 1 + TI / TM);
      repeat (4) @(posedge CORE_CLK);
      runs(3'b100);
      apb(1'b1, OSC_OFS, 32'h4, 32'h0, 1'b0, r);
      repeat (2000) @(posedge CORE_CLK);
      apb(1'b1, OSC_OFS, 32'hc, 32'h0, 1'b0, r);
      settle();
      apb(1'b1, OSC_OFS, 32'h8, 32'h0, 1'b0, r);
      repeat (4) @(posedge CORE_CLK);
      runs(3'b111);
      apb(1'b1, OSC_OFS, 32'h0, 32'h0, 1'b0, r);
      settle();
      repeat (4) @(posedge CORE_CLK);
      runs(3'b101);
      finish_test();
   end

   initial begin
      repeat (60000) @(posedge CORE_CLK);
      bad_count++;
      finish_test();
   end
endmodule
